//--- src/mad_pkg.sv
/*
 * constants shared by the motor algorithm debug register group: register
 * offsets, field positions and widths, reset values and override scaling.
 * assumes the register access port carries a 12-bit byte offset.
 */
package mad_pkg;

    // ==================================================================
    // access port
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ==================================================================
    // register offsets, as printed
    localparam logic [ADDR_W-1:0] OFF_DEBUG_CONTROL_TWO = 12'h0ee;
    localparam logic [ADDR_W-1:0] OFF_CURRENT_GAIN_READBACK = 12'h0f0;
    localparam logic [ADDR_W-1:0] OFF_SPEED_GAIN_READBACK = 12'h0f2;
    localparam logic [ADDR_W-1:0] OFF_MONITOR_ONE_CONTROL = 12'h0f4;

    // ==================================================================
    // debug control two fields
    localparam int BIT_INNER_LOOP_BYPASS = 26;
    localparam int D_OVR_LSB = 16;
    localparam int Q_OVR_LSB = 6;
    localparam int OVR_W = 10;
    localparam int BIT_MEASURE_START = 5;
    localparam int BIT_RESISTANCE = 4;
    localparam int BIT_INDUCTANCE = 3;
    localparam int BIT_BACKEMF = 2;
    localparam int BIT_MECHANICAL = 1;
    localparam int BIT_COPY_SHADOW = 0;
    localparam int MEAS_EN_LSB = 1;
    localparam int MEAS_EN_W = 4;
    localparam logic [OVR_W-1:0] OVR_RESET = 10'h000;
    localparam logic [MEAS_EN_W-1:0] MEAS_EN_RESET = 4'h0;

    // ==================================================================
    // override scaling: reference = numerator / 500
    localparam int REF_W = 11;
    localparam logic [OVR_W-1:0] OVR_POS_LIMIT = 10'h1f4;
    localparam logic [OVR_W-1:0] OVR_NEG_START = 10'h200;
    localparam logic [REF_W-1:0] OVR_WRAP = 11'h400;
    localparam logic [REF_W-1:0] REF_RESET = 11'h000;

    // ==================================================================
    // gain readback fields
    localparam int GAIN_W = 16;
    localparam int KI_LSB = 16;
    localparam int KP_LSB = 0;

    // ==================================================================
    // monitor output one control fields
    localparam int MON_ADDR_LSB = 0;
    localparam int MON_ADDR_W = 12;
    localparam int MON_POL_BIT = 12;
    localparam int MON_SCALE_LSB = 13;
    localparam int MON_ENUM_LSB = 17;
    localparam int MON_SCALE_W = 4;
    localparam logic [MON_ADDR_W-1:0] MON_ADDR_RESET = 12'h000;
    localparam logic [MON_SCALE_W-1:0] MON_SCALE_RESET = 4'h0;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

endpackage

//--- src/mad_override_map.sv
/*
 * maps a 10-bit voltage override code to the signed numerator of the
 * modulation reference (reference = numerator / 500). purely combinational.
 * assumes the caller registers the result.
 */
`timescale 1ns/1ps

module mad_override_map
    import mad_pkg::*;
(
    // override code in
    input wire logic [OVR_W-1:0] code,
    // signed numerator out
    output logic signed [REF_W-1:0] ref_num
);

    // ==================================================================
    // mapping
    // codes 500..511 are outside the valid range; they saturate at +500
    // rather than jump to a large negative value.
    always_comb begin
        if (code < OVR_POS_LIMIT) begin
            ref_num = signed'(REF_W'(code));
        end else if (code < OVR_NEG_START) begin
            ref_num = signed'(REF_W'(OVR_POS_LIMIT));
        end else begin
            ref_num = signed'(REF_W'(REF_W'(code) - OVR_WRAP));
        end
    end

endmodule // mad_override_map

//--- src/mad_debug_regs.sv
/*
 * volatile debug register group of the motor control algorithm: voltage
 * overrides with loop bypass, parameter measurement command and enables,
 * active pi gain readback and monitor output one control.
 * assumes a single-cycle register access port on ref_clk and gain inputs
 * driven by the control algorithm on the same clock.
 */
`timescale 1ns/1ps

module mad_debug_regs
    import mad_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register access port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata_ff,
    output logic reg_rd_valid_ff,
    // gains in use by the control algorithm
    input wire logic [GAIN_W-1:0] active_current_integral_gain,
    input wire logic [GAIN_W-1:0] active_current_proportional_gain,
    input wire logic [GAIN_W-1:0] active_speed_integral_gain,
    input wire logic [GAIN_W-1:0] active_speed_proportional_gain,
    // loop bypass and modulation override
    output logic inner_loop_bypass_ff,
    output logic speed_loop_bypass_ff,
    output logic signed [REF_W-1:0] d_mod_ref_ff,
    output logic signed [REF_W-1:0] q_mod_ref_ff,
    // parameter measurement routine
    output logic param_measure_start_ff,
    output logic resistance_measure_enable_ff,
    output logic inductance_measure_enable_ff,
    output logic backemf_measure_enable_ff,
    output logic mechanical_measure_enable_ff,
    output logic measured_copy_to_shadow_ff,
    // monitor output one
    output logic [MON_ADDR_W-1:0] monitor_one_variable_address_ff,
    output logic [MON_SCALE_W-1:0] monitor_one_scale_ff,
    output logic [MON_SCALE_W-1:0] monitor_one_enum_scale_ff,
    output logic monitor_one_polarity_ff
);

    // ==================================================================
    // decode
    logic wr_debug;
    logic wr_monitor;
    logic bypass_ctl_ff;
    logic [OVR_W-1:0] d_ovr_ff;
    logic [OVR_W-1:0] q_ovr_ff;
    logic signed [REF_W-1:0] d_map;
    logic signed [REF_W-1:0] q_map;
    logic [DATA_W-1:0] nxt_rdata;

    assign wr_debug = reg_wr_en && (reg_addr == OFF_DEBUG_CONTROL_TWO);
    assign wr_monitor = reg_wr_en && (reg_addr == OFF_MONITOR_ONE_CONTROL);

    // ==================================================================
    // override fields and loop bypass
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bypass_ctl_ff <= 1'b0;
            d_ovr_ff <= OVR_RESET;
            q_ovr_ff <= OVR_RESET;
        end else if (wr_debug) begin
            bypass_ctl_ff <= reg_wdata[BIT_INNER_LOOP_BYPASS];
            d_ovr_ff <= reg_wdata[D_OVR_LSB +: OVR_W];
            q_ovr_ff <= reg_wdata[Q_OVR_LSB +: OVR_W];
        end
    end

    mad_override_map u_d_map (
        .code(d_ovr_ff),
        .ref_num(d_map)
    );

    mad_override_map u_q_map (
        .code(q_ovr_ff),
        .ref_num(q_map)
    );

    // references are held at zero while the loops run, so a stale override
    // never reaches the modulator when the bypass is released.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            inner_loop_bypass_ff <= 1'b0;
            speed_loop_bypass_ff <= 1'b0;
            d_mod_ref_ff <= signed'(REF_RESET);
            q_mod_ref_ff <= signed'(REF_RESET);
        end else begin
            inner_loop_bypass_ff <= bypass_ctl_ff;
            speed_loop_bypass_ff <= bypass_ctl_ff;
            d_mod_ref_ff <= bypass_ctl_ff ? d_map : signed'(REF_RESET);
            q_mod_ref_ff <= bypass_ctl_ff ? q_map : signed'(REF_RESET);
        end
    end

    // ==================================================================
    // parameter measurement command and enables
    // enables are taken from the same write that carries the start bit,
    // and are settled on the edge that raises the start pulse.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            resistance_measure_enable_ff <= 1'b0;
            inductance_measure_enable_ff <= 1'b0;
            backemf_measure_enable_ff <= 1'b0;
            mechanical_measure_enable_ff <= 1'b0;
        end else if (wr_debug) begin
            resistance_measure_enable_ff <= reg_wdata[BIT_RESISTANCE];
            inductance_measure_enable_ff <= reg_wdata[BIT_INDUCTANCE];
            backemf_measure_enable_ff <= reg_wdata[BIT_BACKEMF];
            mechanical_measure_enable_ff <= reg_wdata[BIT_MECHANICAL];
        end
    end

    // command bits act as one-cycle strobes; they do not stick
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            param_measure_start_ff <= 1'b0;
            measured_copy_to_shadow_ff <= 1'b0;
        end else begin
            param_measure_start_ff <= wr_debug && reg_wdata[BIT_MEASURE_START];
            measured_copy_to_shadow_ff <= wr_debug && reg_wdata[BIT_COPY_SHADOW];
        end
    end

    // ==================================================================
    // monitor output one control
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            monitor_one_variable_address_ff <= MON_ADDR_RESET;
            monitor_one_scale_ff <= MON_SCALE_RESET;
            monitor_one_enum_scale_ff <= MON_SCALE_RESET;
            monitor_one_polarity_ff <= 1'b0;
        end else if (wr_monitor) begin
            monitor_one_variable_address_ff <= reg_wdata[MON_ADDR_LSB +: MON_ADDR_W];
            monitor_one_scale_ff <= reg_wdata[MON_SCALE_LSB +: MON_SCALE_W];
            monitor_one_enum_scale_ff <= reg_wdata[MON_ENUM_LSB +: MON_SCALE_W];
            monitor_one_polarity_ff <= reg_wdata[MON_POL_BIT];
        end
    end

    // ==================================================================
    // read path
    // write-only fields and unmapped offsets read as zero
    always_comb begin
        nxt_rdata = READ_ZERO;
        case (reg_addr)
            OFF_CURRENT_GAIN_READBACK: begin
                nxt_rdata[KI_LSB +: GAIN_W] = active_current_integral_gain;
                nxt_rdata[KP_LSB +: GAIN_W] = active_current_proportional_gain;
            end
            OFF_SPEED_GAIN_READBACK: begin
                nxt_rdata[KI_LSB +: GAIN_W] = active_speed_integral_gain;
                nxt_rdata[KP_LSB +: GAIN_W] = active_speed_proportional_gain;
            end
            OFF_MONITOR_ONE_CONTROL: begin
                nxt_rdata[MON_ADDR_LSB +: MON_ADDR_W] = monitor_one_variable_address_ff;
            end
            default: begin
                nxt_rdata = READ_ZERO;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff <= READ_ZERO;
            reg_rd_valid_ff <= 1'b0;
        end else begin
            reg_rd_valid_ff <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata_ff <= nxt_rdata;
            end
        end
    end

    // ==================================================================
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_debug_write;
        wr_debug;
    endsequence

    sequence s_bypass_write;
        wr_debug && reg_wdata[BIT_INNER_LOOP_BYPASS];
    endsequence

    sequence s_monitor_write;
        wr_monitor;
    endsequence

    sequence s_monitor_read;
        reg_rd_en && !reg_wr_en && (reg_addr == OFF_MONITOR_ONE_CONTROL);
    endsequence

    sequence s_copy_write;
        wr_debug && reg_wdata[BIT_COPY_SHADOW];
    endsequence

    chk_q_positive_ref: assert property (
        (bypass_ctl_ff && (q_ovr_ff < OVR_POS_LIMIT))
        |=> (q_mod_ref_ff == signed'(REF_W'($past(q_ovr_ff))))
    ) else $error("q reference does not follow positive override code");

    chk_q_negative_ref: assert property (
        (bypass_ctl_ff && (q_ovr_ff >= OVR_NEG_START))
        |=> (q_mod_ref_ff < 0) && (REF_W'(q_mod_ref_ff + OVR_WRAP) == REF_W'($past(q_ovr_ff)))
    ) else $error("q reference does not wrap negative override code");

    chk_bypass_both_loops: assert property (
        s_bypass_write ##1 !wr_debug
        |=> inner_loop_bypass_ff && speed_loop_bypass_ff
    ) else $error("bypass write did not disable both loops two cycles later");

    chk_refs_idle_unbypassed: assert property (
        !inner_loop_bypass_ff |-> (d_mod_ref_ff == 0) && (q_mod_ref_ff == 0)
    ) else $error("override reference present while loops are active");

    chk_start_strobe: assert property (
        (wr_debug && reg_wdata[BIT_MEASURE_START]) ##1 !wr_debug
        |-> param_measure_start_ff ##1 !param_measure_start_ff
    ) else $error("measurement start is not a single-cycle strobe");

    chk_start_only_write: assert property (
        !(wr_debug && reg_wdata[BIT_MEASURE_START]) |=> !param_measure_start_ff
    ) else $error("measurement start without a start write");

    chk_enables_with_start: assert property (
        s_debug_write |=> ({resistance_measure_enable_ff, inductance_measure_enable_ff,
            backemf_measure_enable_ff, mechanical_measure_enable_ff}
            == $past(reg_wdata[MEAS_EN_LSB +: MEAS_EN_W]))
    ) else $error("measurement enables not captured by the debug write");

    chk_copy_strobe: assert property (
        measured_copy_to_shadow_ff |-> $past(wr_debug && reg_wdata[BIT_COPY_SHADOW])
    ) else $error("copy to shadow without a copy write");

    chk_current_gains: assert property (
        (reg_rd_en && (reg_addr == OFF_CURRENT_GAIN_READBACK))
        |=> reg_rd_valid_ff && (reg_rdata_ff == {$past(active_current_integral_gain),
            $past(active_current_proportional_gain)})
    ) else $error("current gain readback mismatch");

    chk_speed_gains: assert property (
        (reg_rd_en && (reg_addr == OFF_SPEED_GAIN_READBACK))
        |=> reg_rd_valid_ff && (reg_rdata_ff == {$past(active_speed_integral_gain),
            $past(active_speed_proportional_gain)})
    ) else $error("speed gain readback mismatch");

    chk_monitor_address: assert property (
        s_monitor_write ##1 s_monitor_read
        |=> reg_rd_valid_ff && (reg_rdata_ff == DATA_W'($past(reg_wdata[MON_ADDR_LSB +: MON_ADDR_W], 2)))
    ) else $error("monitor address does not read back as written");

    // software usually leaves an idle cycle between the write and the read
    chk_monitor_after_gap: assert property (
        s_monitor_write ##1 !reg_wr_en ##1 s_monitor_read
        |=> reg_rd_valid_ff
            && (reg_rdata_ff == DATA_W'($past(reg_wdata[MON_ADDR_LSB +: MON_ADDR_W], 3)))
    ) else $error("monitor address does not read back after an idle cycle");

    chk_d_positive_ref: assert property (
        (bypass_ctl_ff && (d_ovr_ff < OVR_POS_LIMIT))
        |=> (d_mod_ref_ff == signed'(REF_W'($past(d_ovr_ff))))
    ) else $error("d reference does not follow positive override code");

    chk_d_negative_ref: assert property (
        (bypass_ctl_ff && (d_ovr_ff >= OVR_NEG_START))
        |=> (d_mod_ref_ff < 0) && (REF_W'(d_mod_ref_ff + OVR_WRAP) == REF_W'($past(d_ovr_ff)))
    ) else $error("d reference does not wrap negative override code");

    chk_copy_single: assert property (
        s_copy_write ##1 !wr_debug
        |-> measured_copy_to_shadow_ff ##1 !measured_copy_to_shadow_ff
    ) else $error("copy to shadow is not a single-cycle strobe");

    chk_enables_hold: assert property (
        !wr_debug |=> $stable({resistance_measure_enable_ff, inductance_measure_enable_ff,
            backemf_measure_enable_ff, mechanical_measure_enable_ff})
    ) else $error("measurement enables changed without a debug write");

endmodule // mad_debug_regs

//--- dv/mad_debug_regs_tb.sv
/*
 * self-checking bench for the motor algorithm debug register group:
 * override mapping, measurement strobes and enables, gain readback,
 * monitor one control and refused accesses.
 * assumes mad_pkg and the design sources are compiled before this file.
 */
`timescale 1ns/1ps

module mad_debug_regs_tb;
    import mad_pkg::*;

    // ==================================================================
    // stimulus and observed signals
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata_ff;
    logic reg_rd_valid_ff;
    logic [GAIN_W-1:0] cki = '0, ckp = '0, ski = '0, skp = '0;
    logic byp, sbyp, start, en_r, en_i, en_b, en_m, copy, mpol;
    logic signed [REF_W-1:0] dref, qref;
    logic [MON_ADDR_W-1:0] maddr;
    logic [MON_SCALE_W-1:0] mscale, menum;
    logic [DATA_W-1:0] rd_q[$];
    logic [5:0] pulse_q[$];
    int fails = 0;
    int checks = 0;

    always #25 ref_clk = ~ref_clk;

    mad_debug_regs i_mad_debug_regs (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rd_valid_ff(reg_rd_valid_ff),
        .active_current_integral_gain(cki), .active_current_proportional_gain(ckp),
        .active_speed_integral_gain(ski), .active_speed_proportional_gain(skp),
        .inner_loop_bypass_ff(byp), .speed_loop_bypass_ff(sbyp),
        .d_mod_ref_ff(dref), .q_mod_ref_ff(qref), .param_measure_start_ff(start),
        .resistance_measure_enable_ff(en_r), .inductance_measure_enable_ff(en_i),
        .backemf_measure_enable_ff(en_b), .mechanical_measure_enable_ff(en_m),
        .measured_copy_to_shadow_ff(copy), .monitor_one_variable_address_ff(maddr),
        .monitor_one_scale_ff(mscale), .monitor_one_enum_scale_ff(menum),
        .monitor_one_polarity_ff(mpol)
    );

    // ==================================================================
    // comparison and verdict
    task automatic note(input logic [31:0] e, input logic [31:0] a);
        checks++;
        if (e !== a) begin
            fails++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask

    task automatic cmp_rd(input logic [31:0] e, input logic [31:0] a);
        note(e, a);
    endtask

    task automatic cmp_pulse(input logic [5:0] e, input logic [5:0] a);
        note({26'h0, e}, {26'h0, a});
    endtask

    task automatic cmp_ovr(input logic [23:0] e, input logic [23:0] a);
        note({8'h00, e}, {8'h00, a});
    endtask

    task automatic cmp_mon(input logic [20:0] e, input logic [20:0] a);
        note({11'h0, e}, {11'h0, a});
    endtask

    task automatic give_verdict();
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==================================================================
    // output watchers: an empty queue leaves x, which never matches
    always @(negedge ref_clk) begin
        if (reg_rd_valid_ff === 1'b1)
            cmp_rd(rd_q.size() ? rd_q.pop_front() : 32'hxxxx_xxxx, reg_rdata_ff);
        if (start === 1'b1 || copy === 1'b1)
            cmp_pulse(pulse_q.size() ? pulse_q.pop_front() : 'x,
                      {start, copy, en_r, en_i, en_b, en_m});
    end

    // ==================================================================
    // register access
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge ref_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        rd_q.push_back(e);
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
    endtask

    function automatic logic [REF_W-1:0] emap(input logic [OVR_W-1:0] c);
        if (c < OVR_POS_LIMIT)
            return {1'b0, c};
        if (c < OVR_NEG_START)
            return {1'b0, OVR_POS_LIMIT};
        return {1'b0, c} - OVR_WRAP;
    endfunction

    // bypass and references settle one edge after the taking edge
    task automatic ovr(input logic b, input logic [OVR_W-1:0] dc, input logic [OVR_W-1:0] qc);
        logic [REF_W-1:0] ed, eq;
        ed = b ? emap(dc) : REF_RESET;
        eq = b ? emap(qc) : REF_RESET;
        wr(OFF_DEBUG_CONTROL_TWO, {5'h00, b, dc, qc, 6'h00});
        @(posedge ref_clk);
        @(negedge ref_clk);
        cmp_ovr({b, b, ed, eq}, {byp, sbyp, dref, qref});
    endtask

    // ==================================================================
    // main sequence
    logic [OVR_W-1:0] codes[8] = '{10'h000, 10'h001, 10'h064, 10'h1f3,
                                   10'h1f4, 10'h200, 10'h201, 10'h3e8};
    logic [DATA_W-1:0] g, h;
    logic cp;

    initial begin
        void'($urandom(32'hc8ef));
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(OFF_MONITOR_ONE_CONTROL, READ_ZERO);
        foreach (codes[k])
            ovr(1'b1, codes[7-k], codes[k]);
        ovr(1'b0, 10'h12c, 10'h2bc);
        for (int p = 0; p < 16; p++) begin
            cp = 1'($urandom());
            pulse_q.push_back({1'b1, cp, 4'(p)});
            wr(OFF_DEBUG_CONTROL_TWO, {26'h0, 1'b1, 4'(p), cp});
        end
        wr(OFF_DEBUG_CONTROL_TWO, {26'h0, 1'b0, 4'h9, 1'b0});
        pulse_q.push_back({2'b01, 4'h6});
        wr(OFF_DEBUG_CONTROL_TWO, {26'h0, 1'b0, 4'h6, 1'b1});
        @(posedge ref_clk);
        repeat (8) begin
            g = $urandom();
            h = $urandom();
            cki <= g[31:16];
            ckp <= g[15:0];
            ski <= h[31:16];
            skp <= h[15:0];
            rd(OFF_CURRENT_GAIN_READBACK, g);
            rd(OFF_SPEED_GAIN_READBACK, h);
        end
        wr(OFF_CURRENT_GAIN_READBACK, 32'hffff_ffff);
        rd(OFF_CURRENT_GAIN_READBACK, g);
        wr(OFF_SPEED_GAIN_READBACK, 32'h0000_0000);
        rd(OFF_SPEED_GAIN_READBACK, h);
        wr(12'h0f8, 32'hffff_ffff);
        rd(12'h0f8, READ_ZERO);
        rd(OFF_DEBUG_CONTROL_TWO, READ_ZERO);
        repeat (4) begin
            g = $urandom();
            wr(OFF_MONITOR_ONE_CONTROL, g);
            rd(OFF_MONITOR_ONE_CONTROL, {20'h0_0000, g[11:0]});
            @(negedge ref_clk);
            cmp_mon(g[20:0], {menum, mscale, mpol, maddr});
        end
        // a mid-run reset must clear every field, strobe and reference
        ovr(1'b1, 10'h064, 10'h3e8);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        cmp_ovr(24'h00_0000, {byp, sbyp, dref, qref});
        cmp_pulse(6'h0, {start, copy, en_r, en_i, en_b, en_m});
        cmp_mon(21'h0, {menum, mscale, mpol, maddr});
        rd(OFF_MONITOR_ONE_CONTROL, READ_ZERO);
        repeat (3) @(posedge ref_clk);
        note(32'h0000_0000, 32'(rd_q.size() + pulse_q.size()));
        give_verdict();
    end

    // ==================================================================
    // watchdog, roughly fourteen times the expected run
    initial begin
        #100_000;
        fails++;
        give_verdict();
    end

endmodule // mad_debug_regs_tb
